// ===== ebs_pkg.sv
// Purpose: shared constants and types for the external bus cycle sequencer
// Assumes: 100 MHz system clock, all pins synchronous to it
// Notes: one clock per bus pin lag, pins are registered from the sequencer state
package ebs_pkg;

    localparam int ADDR_W = 24;
    localparam int DATA_W = 8;
    localparam int LEN_W = 4;
    localparam int CLK_PERIOD_NS = 10;

    // programmable state length range, in system clocks
    localparam logic [3:0] LEN_MIN = 4'h2;
    localparam logic [3:0] LEN_MAX = 4'hf;

    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_ONE = 4'h1;

    // bus styles
    localparam logic STYLE_MUX = 1'b0;
    localparam logic STYLE_STROBE = 1'b1;

    // synchroniser idle levels: ready high, acknowledge released high
    localparam logic [1:0] SYNC_IDLE = 2'h3;
    localparam int SYNC_GO = 0;
    localparam int SYNC_ACK = 1;

    typedef enum logic [4:0] {
        ST_IDLE, ST_GAP,
        ST_T1, ST_T2, ST_T3, ST_TW, ST_T4,
        ST_S0, ST_S1, ST_S2, ST_S3, ST_S4, ST_SW, ST_S5, ST_S6, ST_S7
    } ebs_state_t;

    typedef struct packed {
        logic style;
        logic write;
        logic io;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } ebs_req_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dout;
        logic data_oe_n;
        logic cs_n;
        logic address_latch_pulse;
        logic read_strobe_n;
        logic store_strobe_n;
        logic memory_cycle_strobe_n;
        logic io_cycle_strobe_n;
        logic address_strobe_n;
        logic data_strobe_n;
        logic direction_select;
    } ebs_pins_t;

    localparam ebs_req_t REQ_RESET = '0;

endpackage

// ===== ebs_sync2.sv
// Purpose: two flop synchroniser for asynchronous peripheral inputs
// Assumes: first stage is read only by the second stage
// Notes: resets each input to its IDLE level, which for ready is its asserted level
`timescale 1ns/1ns
module ebs_sync2 #(
    parameter int WIDTH = 2,
    parameter logic [WIDTH-1:0] IDLE = '1
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            meta <= IDLE;
            dout <= IDLE;
        end else if (ce) begin
            meta <= din;
            dout <= meta;
        end
    end

endmodule

// ===== ebs_state_timer.sv
// Purpose: counts system clocks within one bus state
// Assumes: len is already clamped to the legal range
// Notes: state_end marks the last clock of each timed state and stays low while clear is high
`timescale 1ns/1ns
module ebs_state_timer (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic clear,
    input wire logic [ebs_pkg::LEN_W-1:0] len,
    output logic [ebs_pkg::LEN_W-1:0] cnt,
    output logic state_end
);

    logic [ebs_pkg::LEN_W-1:0] last;

    assign last = ebs_pkg::LEN_W'(len - ebs_pkg::CNT_ONE);
    assign state_end = !clear && (cnt == last);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt <= ebs_pkg::CNT_ZERO;
        end else if (ce) begin
            if (clear || cnt == last) begin
                cnt <= ebs_pkg::CNT_ZERO;
            end else begin
                cnt <= ebs_pkg::LEN_W'(cnt + ebs_pkg::CNT_ONE);
            end
        end
    end

endmodule

// ===== ebs_seq.sv
// Purpose: external bus cycle sequencer, multiplexed and strobe styles
// Assumes: one request at a time from the cpu side, pins synchronous to clk
// Notes: bus pins are registered and trail the sequencer state by one clock
//
// Contract
// R01 - multiplexed cycle is T1..T4, waits before T4
// R02 - T1 puts address on data, select asserted
// R03 - latch pulse high first half of T1
// R04 - read T2 releases data, asserts read strobes
// R05 - ready low before T3 inserts wait states
// R06 - T3 keeps all outputs as in T2
// R07 - read data captured at T4 start
// R08 - write T2 drives data, asserts store strobe
// R09 - write T4 drops strobe, holds lines
// R10 - strobe cycle is S0..S7 plus waits
// R11 - read sets direction high, address at S1
// R12 - read asserts both strobes at S2
// R13 - S4 waits for acknowledge, else wait states
// R14 - each wait lasts one whole bus state
// R15 - peripheral drives read data in S6
// R16 - entering S7 capture data, drop strobes
// R17 - peripheral releases acknowledge at S7
// R18 - write S0 returns direction high
// R19 - write S2 asserts address strobe, direction low
// R20 - write S3 drives data lines
// R21 - write S4 asserts data strobe, S5-S6 steady
// R22 - write S7 drops strobes, direction high after
// R23 - only low address byte shares data lines
// R24 - state length programmable two to fifteen
// R25 - style change adds one idle clock
// R26 - ready and acknowledge inputs synchronised
`timescale 1ns/1ns
module ebs_seq (
    input wire logic clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [ebs_pkg::LEN_W-1:0] state_len,
    input wire logic req_valid,
    output logic req_ready,
    input wire ebs_pkg::ebs_req_t req,
    output logic done,
    output logic [ebs_pkg::DATA_W-1:0] rdata,
    output ebs_pkg::ebs_pins_t pins,
    input wire logic [ebs_pkg::DATA_W-1:0] data_in,
    input wire logic peripheral_go,
    input wire logic transfer_acknowledge_n
);

    ebs_pkg::ebs_state_t state;
    ebs_pkg::ebs_state_t next_state;
    ebs_pkg::ebs_req_t cur;
    logic [ebs_pkg::LEN_W-1:0] eff_len;
    logic [ebs_pkg::LEN_W-1:0] half;
    logic [ebs_pkg::LEN_W-1:0] cnt;
    logic state_end;
    logic timer_clear;
    logic [1:0] sync_in;
    logic [1:0] sync_out;
    logic go_s;
    logic ack_s;
    logic wait_pend;
    logic last_style;
    logic have_prev;
    logic switch_style;
    logic accept;

    // clamp keeps a misprogrammed length from shrinking a state below two clocks
    function automatic logic [ebs_pkg::LEN_W-1:0] clamp_len(
        input logic [ebs_pkg::LEN_W-1:0] l
    );
        if (l < ebs_pkg::LEN_MIN) begin
            return ebs_pkg::LEN_MIN;
        end
        return l;
    endfunction

    // first base state of a cycle in the given style
    function automatic ebs_pkg::ebs_state_t first_state(
        input logic style
    );
        if (style == ebs_pkg::STYLE_STROBE) begin
            return ebs_pkg::ST_S0;
        end
        return ebs_pkg::ST_T1;
    endfunction

    function automatic ebs_pkg::ebs_pins_t drive(
        input ebs_pkg::ebs_state_t s,
        input logic [ebs_pkg::LEN_W-1:0] c,
        input logic [ebs_pkg::LEN_W-1:0] h,
        input ebs_pkg::ebs_req_t r
    );
        ebs_pkg::ebs_pins_t p;
        p = '0;
        p.addr = r.addr;
        p.dout = r.wdata;
        p.data_oe_n = 1'b1;
        p.cs_n = 1'b1;
        p.address_latch_pulse = 1'b0;
        p.read_strobe_n = 1'b1;
        p.store_strobe_n = 1'b1;
        p.memory_cycle_strobe_n = 1'b1;
        p.io_cycle_strobe_n = 1'b1;
        p.address_strobe_n = 1'b1;
        p.data_strobe_n = 1'b1;
        p.direction_select = 1'b1;
        case (s)
            // R02 address on data lines
            ebs_pkg::ST_T1: begin
                p.cs_n = 1'b0;
                p.data_oe_n = 1'b0;
                // R23 low byte only
                p.dout = r.addr[ebs_pkg::DATA_W-1:0];
                // R03 latch pulse half
                p.address_latch_pulse = (c < h);
            end
            // R06 T3 same as T2
            ebs_pkg::ST_T2, ebs_pkg::ST_T3, ebs_pkg::ST_TW: begin
                p.cs_n = 1'b0;
                p.memory_cycle_strobe_n = r.io;
                p.io_cycle_strobe_n = !r.io;
                if (r.write) begin
                    // R08 write data out
                    p.data_oe_n = 1'b0;
                    p.store_strobe_n = 1'b0;
                end else begin
                    // R04 release, read strobe
                    p.read_strobe_n = 1'b0;
                end
            end
            // R09 hold lines, drop strobe
            ebs_pkg::ST_T4: begin
                p.cs_n = 1'b0;
                p.memory_cycle_strobe_n = r.io;
                p.io_cycle_strobe_n = !r.io;
                p.data_oe_n = !r.write;
            end
            // R11 direction high in S0
            // R18 write also starts high
            ebs_pkg::ST_S0: begin
                p.direction_select = 1'b1;
            end
            ebs_pkg::ST_S1: begin
                p.cs_n = 1'b0;
            end
            // R12 both strobes at S2
            ebs_pkg::ST_S2: begin
                p.cs_n = 1'b0;
                p.address_strobe_n = 1'b0;
                p.data_strobe_n = r.write;
                // R19 write direction low
                p.direction_select = !r.write;
            end
            // R20 write data driven
            ebs_pkg::ST_S3: begin
                p.cs_n = 1'b0;
                p.address_strobe_n = 1'b0;
                p.data_strobe_n = r.write;
                p.direction_select = !r.write;
                p.data_oe_n = !r.write;
            end
            // R21 data strobe from S4
            ebs_pkg::ST_S4, ebs_pkg::ST_SW, ebs_pkg::ST_S5, ebs_pkg::ST_S6: begin
                p.cs_n = 1'b0;
                p.address_strobe_n = 1'b0;
                p.data_strobe_n = 1'b0;
                p.direction_select = !r.write;
                p.data_oe_n = !r.write;
            end
            // R22 strobes off in S7
            ebs_pkg::ST_S7: begin
                p.cs_n = 1'b0;
                p.direction_select = !r.write;
                p.data_oe_n = !r.write;
            end
            default: begin
                p.data_oe_n = 1'b1;
            end
        endcase
        return p;
    endfunction

    // R24 programmable length
    assign eff_len = clamp_len(state_len);
    assign half = eff_len >> 1;

    // R26 input synchronisers
    assign sync_in[ebs_pkg::SYNC_GO] = peripheral_go;
    assign sync_in[ebs_pkg::SYNC_ACK] = transfer_acknowledge_n;

    ebs_sync2 #(
        .WIDTH(2),
        .IDLE(ebs_pkg::SYNC_IDLE)
    ) u_sync (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .din(sync_in),
        .dout(sync_out)
    );

    assign go_s = sync_out[ebs_pkg::SYNC_GO];
    assign ack_s = !sync_out[ebs_pkg::SYNC_ACK];

    assign timer_clear = (state == ebs_pkg::ST_IDLE) || (state == ebs_pkg::ST_GAP);

    ebs_state_timer u_timer (
        .clk(clk),
        .resetn(resetn),
        .ce(ce),
        .clear(timer_clear),
        .len(eff_len),
        .cnt(cnt),
        .state_end(state_end)
    );

    // R25 style change gap
    assign switch_style = have_prev && (req.style != last_style);
    // the gap clock takes the request itself, so a style change costs one clock
    assign req_ready = ((state == ebs_pkg::ST_IDLE) && !switch_style)
        || (state == ebs_pkg::ST_GAP);
    assign accept = req_valid && req_ready;

    always_comb begin
        next_state = state;
        case (state)
            ebs_pkg::ST_IDLE: begin
                if (req_valid && switch_style) begin
                    next_state = ebs_pkg::ST_GAP;
                end else if (req_valid) begin
                    next_state = first_state(req.style);
                end
            end
            ebs_pkg::ST_GAP: begin
                if (req_valid) begin
                    next_state = first_state(req.style);
                end else begin
                    next_state = ebs_pkg::ST_IDLE;
                end
            end
            // R01 four base states
            ebs_pkg::ST_T1: if (state_end) next_state = ebs_pkg::ST_T2;
            ebs_pkg::ST_T2: if (state_end) next_state = ebs_pkg::ST_T3;
            ebs_pkg::ST_T3: begin
                // R05 wait after T3
                if (state_end) begin
                    next_state = wait_pend ? ebs_pkg::ST_TW : ebs_pkg::ST_T4;
                end
            end
            ebs_pkg::ST_TW: if (state_end && go_s) next_state = ebs_pkg::ST_T4;
            ebs_pkg::ST_T4: if (state_end) next_state = ebs_pkg::ST_IDLE;
            // R10 eight base states
            ebs_pkg::ST_S0: if (state_end) next_state = ebs_pkg::ST_S1;
            ebs_pkg::ST_S1: if (state_end) next_state = ebs_pkg::ST_S2;
            ebs_pkg::ST_S2: if (state_end) next_state = ebs_pkg::ST_S3;
            ebs_pkg::ST_S3: if (state_end) next_state = ebs_pkg::ST_S4;
            ebs_pkg::ST_S4: begin
                // R13 acknowledge check
                if (state_end) begin
                    next_state = ack_s ? ebs_pkg::ST_S5 : ebs_pkg::ST_SW;
                end
            end
            // R14 whole state wait
            ebs_pkg::ST_SW: if (state_end && ack_s) next_state = ebs_pkg::ST_S5;
            ebs_pkg::ST_S5: if (state_end) next_state = ebs_pkg::ST_S6;
            ebs_pkg::ST_S6: if (state_end) next_state = ebs_pkg::ST_S7;
            // R17 peripheral releases acknowledge here
            ebs_pkg::ST_S7: if (state_end) next_state = ebs_pkg::ST_IDLE;
            default: next_state = ebs_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= ebs_pkg::ST_IDLE;
        end else if (ce) begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cur <= ebs_pkg::REQ_RESET;
        end else if (ce && accept) begin
            cur <= req;
        end
    end

    // R25 remembers the last style run
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            last_style <= ebs_pkg::STYLE_MUX;
            have_prev <= 1'b0;
        end else if (ce) begin
            if (accept || state == ebs_pkg::ST_GAP) begin
                last_style <= req.style;
                have_prev <= 1'b1;
            end
        end
    end

    // R05 ready sampled on last T2 clock
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wait_pend <= 1'b0;
        end else if (ce) begin
            if (state == ebs_pkg::ST_T2 && state_end) begin
                wait_pend <= !go_s;
            end
        end
    end

    // pins trail the state by one clock so every strobe edge is glitch free
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pins <= drive(ebs_pkg::ST_IDLE, ebs_pkg::CNT_ZERO, ebs_pkg::CNT_ZERO,
                          ebs_pkg::REQ_RESET);
        end else if (ce) begin
            pins <= drive(state, cnt, half, cur);
        end
    end

    // R07 capture at T4 start
    // R16 capture entering S7
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata <= '0;
        end else if (ce && !cur.write && cnt == ebs_pkg::CNT_ZERO) begin
            if (state == ebs_pkg::ST_T4 || state == ebs_pkg::ST_S7) begin
                rdata <= data_in;
            end
        end
    end

    // done pulses one clock after the last clock of T4 or S7, in step with the pins
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            done <= 1'b0;
        end else if (ce) begin
            done <= state_end && (state == ebs_pkg::ST_T4 || state == ebs_pkg::ST_S7);
        end
    end

endmodule

// ===== ebs_seq_asserts.sv
// Purpose: pin level checks for the external bus cycle sequencer
// Assumes: clamped state length of two clocks or more
// Notes: states are inferred from the strobes, the checker sees pins only
`timescale 1ns/1ns
module ebs_seq_chk (
    input wire logic clk,
    input wire logic resetn,
    input wire ebs_pkg::ebs_pins_t pins
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    ale_addr_out_a: assert property (
        pins.address_latch_pulse |-> !pins.cs_n && !pins.data_oe_n
        && pins.dout == pins.addr[7:0]) else $error("address not on data lines");
    ale_fall_a: assert property (
        $rose(pins.address_latch_pulse) |-> ##[1:8] !pins.address_latch_pulse)
        else $error("latch pulse too long");
    rd_start_a: assert property (
        $fell(pins.read_strobe_n) |-> pins.data_oe_n && !pins.cs_n
        && !pins.address_latch_pulse
        && (pins.memory_cycle_strobe_n != pins.io_cycle_strobe_n)) else $error("bad read start");
    rd_hold_a: assert property (
        $fell(pins.read_strobe_n) |-> (!pins.read_strobe_n) [*4]) else $error("read strobe short");
    wr_start_a: assert property (
        $fell(pins.store_strobe_n) |-> !pins.data_oe_n && !pins.cs_n
        && pins.read_strobe_n && !pins.address_latch_pulse) else $error("bad write start");
    wr_end_a: assert property (
        $rose(pins.store_strobe_n) |-> !pins.data_oe_n && !pins.cs_n
        && $stable(pins.dout) && $stable(pins.addr)) else $error("write lines dropped");
    rd_both_a: assert property (
        $fell(pins.address_strobe_n) && pins.direction_select |-> $fell(pins.data_strobe_n))
        else $error("read strobes apart");
    wr_dir_a: assert property (
        $fell(pins.address_strobe_n) && !pins.direction_select
        |-> $fell(pins.direction_select) && pins.data_strobe_n) else $error("bad write S2");
    wr_drive_a: assert property (
        $fell(pins.data_oe_n) && !pins.direction_select
        |-> !pins.address_strobe_n && pins.data_strobe_n) else $error("bad write S3");
    end_both_a: assert property (
        $rose(pins.address_strobe_n) |-> $rose(pins.data_strobe_n)
        && (pins.direction_select || !pins.data_oe_n)) else $error("bad strobe end");
    dir_back_a: assert property (
        $rose(pins.direction_select) |-> pins.address_strobe_n && pins.data_strobe_n)
        else $error("direction early");

    cover property ($fell(pins.read_strobe_n));
    cover property ($fell(pins.store_strobe_n));
    cover property ($fell(pins.data_strobe_n) && pins.direction_select);
    cover property ($fell(pins.data_strobe_n) && !pins.direction_select);
endmodule

bind ebs_seq ebs_seq_chk ebs_seq_chk_i (.clk(clk), .resetn(resetn), .pins(pins));

// ===== ebs_periph.sv
// Purpose: behavioural memory chip on the far side of the bus
// Assumes: slow asks for a long ready or acknowledge delay
// Notes: undriven data lines toggle so a stale byte never passes
`timescale 1ns/1ns
module ebs_periph (
    input wire logic clk,
    input wire logic resetn,
    input wire logic slow,
    input wire ebs_pkg::ebs_pins_t pins,
    output logic [7:0] data_in,
    output logic peripheral_go,
    output logic transfer_acknowledge_n
);
    logic [7:0] mem [256];
    logic [7:0] alat;
    logic [7:0] last;
    logic [3:0] hold;
    logic drv;
    logic [7:0] a;
    assign a = pins.address_strobe_n ? alat : pins.addr[7:0];
    assign drv = pins.data_oe_n && !pins.cs_n
        && (!pins.read_strobe_n || (!pins.data_strobe_n && pins.direction_select));
    assign data_in = drv ? mem[a] : ~last;
    assign peripheral_go = hold == 4'h0;
    assign transfer_acknowledge_n = !(hold == 4'h0 && !pins.address_strobe_n);
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hold <= 4'h0;
            last <= 8'h00;
        end else begin
            last <= data_in;
            if (pins.cs_n) begin
                hold <= slow ? 4'hc : 4'h0;
            end else if (hold != 4'h0) begin
                hold <= hold - 4'h1;
            end
        end
    end
    // memory keeps contents over reset, as a real chip would
    always_ff @(posedge clk) begin
        if (pins.address_latch_pulse && !pins.data_oe_n) begin
            alat <= pins.dout;
        end
        if (!pins.store_strobe_n) begin
            mem[alat] <= pins.dout;
        end
        if (!pins.data_strobe_n && !pins.direction_select) begin
            mem[pins.addr[7:0]] <= pins.dout;
        end
    end
endmodule

// ===== testbench.sv
// Purpose: self checking bench for the external bus cycle sequencer
// Assumes: clock enable held high except in its own test
// Notes: latency offset taken from the first row, the rest are relative
`timescale 1ns/1ns
module testbench;
    typedef struct packed {
        logic [3:0] len;
        logic slow;
        ebs_pkg::ebs_req_t r;
    } ebs_row_t;
    // len, slow, style, write, io, addr, wdata
    localparam ebs_row_t rows [9] = '{
        {4'h2, 1'b0, 1'b0, 1'b1, 1'b0, 24'h123455, 8'ha5},
        {4'h2, 1'b0, 1'b0, 1'b0, 1'b0, 24'h123455, 8'h00},
        {4'h3, 1'b1, 1'b0, 1'b1, 1'b1, 24'h00005a, 8'h3c},
        {4'h0, 1'b0, 1'b0, 1'b0, 1'b1, 24'h00005a, 8'h00},
        {4'h2, 1'b0, 1'b1, 1'b1, 1'b0, 24'habcd77, 8'h96},
        {4'h3, 1'b1, 1'b1, 1'b0, 1'b0, 24'habcd77, 8'h00},
        {4'hf, 1'b0, 1'b1, 1'b1, 1'b0, 24'hfe0001, 8'h0f},
        {4'h2, 1'b0, 1'b1, 1'b0, 1'b0, 24'hfe0001, 8'h00},
        {4'h2, 1'b0, 1'b0, 1'b0, 1'b0, 24'h123455, 8'h00}};
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b1;
    logic [3:0] state_len = 4'h2;
    logic req_valid = 1'b0;
    logic slow = 1'b0;
    ebs_pkg::ebs_req_t req = ebs_pkg::REQ_RESET;
    logic req_ready, done, peripheral_go, transfer_acknowledge_n, last_style;
    logic [7:0] rdata, data_in;
    ebs_pkg::ebs_pins_t pins, idle_pins;
    ebs_pkg::ebs_pins_t snap;
    logic [1:0] seen_sel = 2'h0;
    logic [7:0] tmem [256];
    int err_count = 0;
    int checks_done = 0;
    int off, lat, gap, lc;

    always #5 clk = ~clk;

    // remembers which of the memory or io strobes went with the last strobed access
    always @(negedge clk) begin
        if (!pins.read_strobe_n || !pins.store_strobe_n) begin
            seen_sel <= {pins.io_cycle_strobe_n, pins.memory_cycle_strobe_n};
        end
    end

    ebs_seq ebs_seq_i (.clk(clk), .resetn(resetn), .ce(ce), .state_len(state_len),
        .req_valid(req_valid), .req_ready(req_ready), .req(req), .done(done),
        .rdata(rdata), .pins(pins), .data_in(data_in), .peripheral_go(peripheral_go),
        .transfer_acknowledge_n(transfer_acknowledge_n));
    ebs_periph ebs_periph_i (.clk(clk), .resetn(resetn), .slow(slow), .pins(pins),
        .data_in(data_in), .peripheral_go(peripheral_go),
        .transfer_acknowledge_n(transfer_acknowledge_n));

    task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_cnt(input int got, input int exp);
        chk_val(64'(got), 64'(exp));
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic wait_done;
        lat = 0;
        while (done !== 1'b1 && lat < 400) begin
            @(posedge clk);
            #1;
            lat++;
        end
    endtask

    // gap counts idle clocks before take, lat counts clocks from take to done
    task automatic op(input ebs_pkg::ebs_req_t r);
        req = r;
        req_valid = 1'b1;
        gap = 0;
        #1;
        while (req_ready !== 1'b1 && gap < 40) begin
            @(posedge clk);
            #1;
            gap++;
        end
        @(posedge clk);
        #1;
        req_valid = 1'b0;
        wait_done;
    endtask

    initial begin
        idle_pins = '1;
        idle_pins.addr = '0;
        idle_pins.dout = '0;
        idle_pins.address_latch_pulse = 1'b0;
        repeat (8) @(posedge clk);
        #1;
        chk_val(pins, idle_pins);
        resetn = 1'b1;
        for (int i = 0; i < 9; i++) begin
            state_len = rows[i].len;
            slow = rows[i].slow;
            op(rows[i].r);
            lc = rows[i].len < 4'h2 ? 2 : int'(rows[i].len);
            if (i == 0) begin
                off = lat - 4 * lc;
            end
            lat = lat - off - (rows[i].r.style ? 8 : 4) * lc;
            if (rows[i].slow) begin
                chk_cnt(int'(lat > 0 && lat % lc == 0), 1);
            end else begin
                chk_cnt(lat, 0);
            end
            chk_cnt(gap, (i > 0 && rows[i].r.style != last_style) ? 1 : 0);
            if (rows[i].r.style == ebs_pkg::STYLE_MUX) begin
                chk_val(seen_sel, rows[i].r.io ? 2'h1 : 2'h2);
            end
            last_style = rows[i].r.style;
            if (rows[i].r.write) begin
                tmem[rows[i].r.addr[7:0]] = rows[i].r.wdata;
            end else begin
                chk_val(rdata, tmem[rows[i].r.addr[7:0]]);
            end
            $display("row %0d finished", i);
        end
        // reset in mid cycle must leave the pins idle at once
        req = rows[4].r;
        req_valid = 1'b1;
        repeat (6) @(posedge clk);
        #1;
        resetn = 1'b0;
        req_valid = 1'b0;
        #1;
        chk_val(pins, idle_pins);
        chk_val({req_ready, done, rdata}, 10'h200);
        @(posedge clk);
        #1;
        resetn = 1'b1;
        op(rows[1].r);
        chk_cnt(gap, 0);
        chk_val(rdata, 8'ha5);
        $display("reset test finished");
        // clock enable low must freeze a taken cycle where it stands
        req = rows[1].r;
        req_valid = 1'b1;
        @(posedge clk);
        #1;
        req_valid = 1'b0;
        ce = 1'b0;
        snap = pins;
        repeat (5) @(posedge clk);
        #1;
        chk_val({done, pins}, {1'b0, snap});
        ce = 1'b1;
        wait_done;
        chk_cnt(lat - off, 8);
        chk_val(rdata, tmem[8'h55]);
        $display("clock enable test finished");
        results;
    end

    initial begin
        #100000;
        err_count++;
        $display("watchdog expired");
        results;
    end
endmodule
